/* include/fspg_defines.svh */
`ifndef FSPG_DEFINES_SVH
`define FSPG_DEFINES_SVH

// Register byte offsets on APB
`define FSPG_CTRL_OFS 12'h000
`define FSPG_STATUS_OFS 12'h004
`define FSPG_LOCK_OFS 12'h008
`define FSPG_BOUND_OFS 12'h00C

// Control register fields
`define FSPG_CTRL_RWW_RE_BIT 0
`define FSPG_CTRL_VEC_BOOT_BIT 1

// Lock register fields, 1 = unprogrammed
`define FSPG_LOCK_APP_WR_BIT 0
`define FSPG_LOCK_APP_RD_BIT 1
`define FSPG_LOCK_BOOT_WR_BIT 2
`define FSPG_LOCK_BOOT_RD_BIT 3
`define FSPG_LOCK_GEN_BIT0 4
`define FSPG_LOCK_GEN_BIT1 5
`define FSPG_LOCK_RESET 6'h3F

// Status register fields
`define FSPG_STAT_BUSY_BIT 0
`define FSPG_STAT_RWW_BUSY_BIT 1
`define FSPG_STAT_REJECT_BIT 2

// Flash geometry, word address width
`define FSPG_ADDR_W 15
`define FSPG_RWW_LIMIT 15'h7000
`define FSPG_BOOT_START_RESET 15'h7C00

`endif

/* include/fspg_lock_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface fspg_lock_if;
  logic [5:0] lock_bits;
  logic boot_pc;
  logic target_boot;
  logic write_ok;
  logic read_ok;
  logic irq_block;
  logic vec_boot;
  modport guard (input lock_bits, boot_pc, target_boot, vec_boot,
    output write_ok, read_ok, irq_block);
  modport core (output lock_bits, boot_pc, target_boot, vec_boot,
    input write_ok, read_ok, irq_block);
endinterface
`default_nettype wire

/* include/fspg_pkg.sv */
package fspg_pkg;
  typedef enum logic [1:0] {
    FSPG_OP_ERASE,
    FSPG_OP_WRITE,
    FSPG_OP_LOCK,
    FSPG_OP_NONE
  } fspg_op_t;

  typedef enum {
    FSPG_IDLE,
    FSPG_RUN
  } fspg_state_t;
endpackage

/* sim/fspg_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fspg_cpu_model (
  // Clock and answers
  input wire logic clk,
  input wire logic flash_start,
  input wire logic lpm_allow,
  // Requests
  output logic [14:0] cpu_pc,
  output logic spm_req,
  output logic [1:0] spm_op,
  output logic [14:0] spm_addr,
  output logic [5:0] spm_lock_data,
  output logic lpm_req,
  output logic [14:0] lpm_addr
);
  // ****
  // Core requests
  // ****
  initial begin
    cpu_pc = 15'h0000;
    spm_req = 1'b0;
    spm_op = 2'h3;
    spm_addr = 15'h0000;
    spm_lock_data = 6'h3F;
    lpm_req = 1'b0;
    lpm_addr = 15'h0000;
  end
  // Boot code keeps running from its own section only while it programs the READ_WHILE_WRITE_SECTION
  task automatic store_program_memory_op(input logic [14:0] pc, input logic [1:0] op, input logic [14:0] a,
    output logic got);
    @(posedge clk);
    cpu_pc <= pc;
    spm_op <= op;
    spm_addr <= a;
    spm_req <= 1'b1;
    @(posedge clk);
    spm_req <= 1'b0;
    spm_addr <= ~a;
    #1 got = flash_start;
  endtask
  task automatic lpm(input logic [14:0] pc, input logic [14:0] a, output logic got);
    @(posedge clk);
    cpu_pc <= pc;
    lpm_addr <= a;
    lpm_req <= 1'b1;
    @(posedge clk);
    lpm_req <= 1'b0;
    lpm_addr <= ~a;
    #1 got = lpm_allow;
  endtask
  // Lock-bit programming by a store-program operation; pattern returns to all ones after
  task automatic lock(input logic [14:0] pc, input logic [5:0] d);
    @(posedge clk);
    cpu_pc <= pc;
    spm_op <= 2'h2;
    spm_lock_data <= d;
    spm_req <= 1'b1;
    @(posedge clk);
    spm_req <= 1'b0;
    spm_lock_data <= 6'h3F;
  endtask
endmodule
`default_nettype wire

/* sim/fspg_guard_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fspg_defines.svh"
module fspg_guard_asserts #(
  parameter logic [14:0] RWW_LIMIT = `FSPG_RWW_LIMIT,
  parameter logic [15:0] PROG_CYCLES = 16'h0040
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // CPU requests
  input wire logic [14:0] cpu_pc,
  input wire logic spm_req,
  input wire logic lpm_req,
  input wire logic [14:0] lpm_addr,
  // Guard decisions
  input wire logic cpu_halt,
  input wire logic rww_fetch_block,
  input wire logic lpm_allow,
  input wire logic flash_start,
  input wire logic [14:0] flash_addr
);
  // ****
  // Halt length counter
  // ****
  logic [15:0] hcnt_reg;
  logic [15:0] hcnt_next;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  always_comb begin
    hcnt_next = cpu_halt ? hcnt_reg + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hcnt_reg <= 16'h0000;
    end else begin
      hcnt_reg <= hcnt_next;
    end
  end
  rww_no_halt_a: assert property (flash_start && flash_addr < RWW_LIMIT |-> !cpu_halt)
    else $error("halt while programming rww");
  no_read_while_write_section_halt_a: assert property (flash_start && flash_addr >= RWW_LIMIT |-> cpu_halt)
    else $error("no halt while programming no_read_while_write_section");
  halt_len_a: assert property ($fell(cpu_halt) |-> hcnt_reg == PROG_CYCLES)
    else $error("halt length wrong");
  busy_set_a: assert property (flash_start |-> rww_fetch_block)
    else $error("busy flag not set");
  // Code below the fixed boundary is always application code, whatever the boot start
  app_spm_a: assert property (spm_req && cpu_pc < RWW_LIMIT |=> !flash_start)
    else $error("op started from app");
  rww_read_a: assert property (rww_fetch_block && lpm_req && lpm_addr < RWW_LIMIT
    |=> !lpm_allow)
    else $error("rww load during busy");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  err_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  cover property (flash_start && cpu_halt);
  cover property (flash_start && !cpu_halt);
  cover property (pslverr);
endmodule
bind fspg_guard fspg_guard_asserts #(.RWW_LIMIT(RWW_LIMIT), .PROG_CYCLES(PROG_CYCLES))
  fspg_guard_asserts_i (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .cpu_pc(cpu_pc), .spm_req(spm_req),
  .lpm_req(lpm_req), .lpm_addr(lpm_addr), .cpu_halt(cpu_halt),
  .rww_fetch_block(rww_fetch_block), .lpm_allow(lpm_allow),
  .flash_start(flash_start), .flash_addr(flash_addr));
`default_nettype wire

/* sim/test_flash_self_program_guard.sv */
`timescale 1ns/10ps
`default_nettype none
module test_flash_self_program_guard;
  logic clk, reset_n, psel, penable, pwrite, chip_erase, pready, pslverr, err, g;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [14:0] pc, sa, la, fa;
  logic spm_req, lpm_req, halt, blk, lal, irq, fs, fe;
  logic [1:0] op;
  logic [5:0] ld;
  int error_cnt = 0;
  int total_checks = 0;
  fspg_guard #(.PROG_CYCLES(16'h0004)) fspg_guard_i (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_pc(pc), .spm_req(spm_req),
    .spm_op(op), .spm_addr(sa), .spm_lock_data(ld), .lpm_req(lpm_req), .lpm_addr(la),
    .chip_erase(chip_erase), .cpu_halt(halt), .rww_fetch_block(blk), .lpm_allow(lal),
    .irq_disable(irq), .flash_start(fs), .flash_is_erase(fe), .flash_addr(fa));
  fspg_cpu_model fspg_cpu_model_i (.clk(clk), .flash_start(fs), .lpm_allow(lal),
    .cpu_pc(pc), .spm_req(spm_req), .spm_op(op), .spm_addr(sa), .spm_lock_data(ld),
    .lpm_req(lpm_req), .lpm_addr(la));
  // ****
  // Tasks
  // ****
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task print_verdict;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    print_verdict;
  end
  initial begin
    {reset_n, psel, penable, pwrite, chip_erase} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    apb(0, 12'h008, 0); chk("lock", rd, 32'h0000003F);
    apb(0, 12'h010, 0); chk("unmapped", err, 1);
    apb(1, 12'h00C, 32'h00006000); chk("bound", err, 1);
    apb(0, 12'h00C, 0); chk("bound kept", rd, 32'h00007C00);
    apb(1, 12'h008, 32'h0000000F);
    fspg_cpu_model_i.store_program_memory_op(15'h0100, 2'h1, 15'h0200, g); chk("app spm", g, 0);
    fspg_cpu_model_i.store_program_memory_op(15'h7C10, 2'h1, 15'h0200, g); chk("rww spm", g, 1);
    chk("write addr", fa, 32'h00000200);
    chk("write op", fe, 0);
    chk("rww halt", halt, 0);
    chk("busy", blk, 1);
    fspg_cpu_model_i.lpm(15'h7C10, 15'h0100, g); chk("rww load", g, 0);
    fspg_cpu_model_i.lpm(15'h7C10, 15'h7100, g); chk("no_read_while_write_section load", g, 1);
    repeat (8) @(posedge clk);
    apb(0, 12'h004, 0); chk("status", rd, 32'h00000002);
    apb(1, 12'h000, 32'h00000001);
    apb(0, 12'h004, 0); chk("cleared", rd, 32'h00000000);
    fspg_cpu_model_i.lpm(15'h7C10, 15'h0100, g); chk("rww reload", g, 1);
    fspg_cpu_model_i.store_program_memory_op(15'h7C10, 2'h0, 15'h7100, g); chk("no_read_while_write_section spm", g, 1);
    chk("no_read_while_write_section halt", halt, 1);
    chk("erase op", fe, 1);
    chk("erase addr", fa, 32'h00007100);
    repeat (8) @(posedge clk);
    chk("halt end", halt, 0);
    apb(1, 12'h000, 32'h00000001);
    apb(1, 12'h008, 32'h0000000C);
    fspg_cpu_model_i.store_program_memory_op(15'h7C10, 2'h1, 15'h0200, g); chk("app wlock", g, 0);
    apb(0, 12'h004, 0); chk("reject", rd, 32'h00000004);
    fspg_cpu_model_i.lpm(15'h7C10, 15'h0100, g); chk("app rlock", g, 0);
    apb(1, 12'h000, 32'h00000002);
    fspg_cpu_model_i.lpm(15'h0100, 15'h0100, g);
    repeat (2) @(posedge clk);
    chk("irq app", irq, 1);
    apb(1, 12'h008, 32'h00000000);
    fspg_cpu_model_i.store_program_memory_op(15'h7C10, 2'h1, 15'h7C20, g); chk("boot wlock", g, 0);
    fspg_cpu_model_i.lpm(15'h0100, 15'h7C20, g); chk("boot rlock", g, 0);
    apb(1, 12'h000, 32'h00000000);
    fspg_cpu_model_i.lpm(15'h7C10, 15'h7C20, g);
    repeat (2) @(posedge clk);
    chk("irq boot", irq, 1);
    chip_erase <= 1'b1;
    @(posedge clk);
    chip_erase <= 1'b0;
    apb(0, 12'h008, 0); chk("erased", rd, 32'h0000003F);
    fspg_cpu_model_i.store_program_memory_op(15'h7C10, 2'h1, 15'h7C20, g); chk("boot free", g, 1);
    repeat (8) @(posedge clk);
    fspg_cpu_model_i.lock(15'h0100, 6'h00);
    fspg_cpu_model_i.lock(15'h7C10, 6'h3B);
    apb(0, 12'h008, 0); chk("spm lock", rd, 32'h0000003B);
    print_verdict;
  end
endmodule
`default_nettype wire

/* verilog/fspg_guard.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fspg_defines.svh"
module fspg_guard #(
  parameter logic [`FSPG_ADDR_W-1:0] RWW_LIMIT = `FSPG_RWW_LIMIT,
  parameter logic [15:0] PROG_CYCLES = 16'h0040
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU program-memory requests
  input wire logic [`FSPG_ADDR_W-1:0] cpu_pc,
  input wire logic spm_req,
  input wire logic [1:0] spm_op,
  input wire logic [`FSPG_ADDR_W-1:0] spm_addr,
  input wire logic [5:0] spm_lock_data,
  input wire logic lpm_req,
  input wire logic [`FSPG_ADDR_W-1:0] lpm_addr,
  input wire logic chip_erase,
  // Guard decisions
  output logic cpu_halt,
  output logic rww_fetch_block,
  output logic lpm_allow,
  output logic irq_disable,
  output logic flash_start,
  output logic flash_is_erase,
  output logic [`FSPG_ADDR_W-1:0] flash_addr
);
  fspg_lock_if lk_w ();
  fspg_lock_if lk_r ();

  fspg_pkg::fspg_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic rww_busy_reg, rww_busy_next;
  logic halt_reg, halt_next;
  logic vec_boot_reg, vec_boot_next;
  logic reject_reg, reject_next;
  logic [5:0] lock_reg, lock_next;
  logic [`FSPG_ADDR_W-1:0] boot_start_reg, boot_start_next;
  logic [31:0] prdata_next;
  logic pslverr_next;
  logic pready_reg, pready_next;
  logic fetch_blk_next, lpm_ok_next, irq_dis_next;
  logic start_next, erase_next;
  logic [`FSPG_ADDR_W-1:0] faddr_next;
  logic lpm_ok_reg, irq_dis_reg, start_reg, erase_reg, fetch_blk_reg;
  logic [`FSPG_ADDR_W-1:0] faddr_reg;

  function automatic logic in_rww(input logic [`FSPG_ADDR_W-1:0] a);
    in_rww = a < RWW_LIMIT;
  endfunction

  function automatic logic in_boot(input logic [`FSPG_ADDR_W-1:0] a,
                                   input logic [`FSPG_ADDR_W-1:0] s);
    in_boot = a >= s;
  endfunction

  logic pc_boot;
  logic apb_wr, apb_rd;
  logic spm_legal;
  fspg_pkg::fspg_op_t op;

  assign pc_boot = in_boot(cpu_pc, boot_start_reg);
  assign apb_wr = psel & penable & pwrite & ~pready_reg;
  assign apb_rd = psel & penable & ~pwrite & ~pready_reg;
  assign op = fspg_pkg::fspg_op_t'(spm_op);

  // Write check against the target section
  assign lk_w.lock_bits = lock_reg;
  assign lk_w.boot_pc = pc_boot;
  assign lk_w.target_boot = in_boot(spm_addr, boot_start_reg);
  assign lk_w.vec_boot = vec_boot_reg;
  fspg_lock_eval u_wr_eval (.lk(lk_w));

  // Load check and interrupt masking for the running code
  assign lk_r.lock_bits = lock_reg;
  assign lk_r.boot_pc = pc_boot;
  assign lk_r.target_boot = in_boot(lpm_addr, boot_start_reg);
  assign lk_r.vec_boot = vec_boot_reg;
  fspg_lock_eval u_rd_eval (.lk(lk_r));

  assign spm_legal = spm_req & pc_boot & (state_reg == fspg_pkg::FSPG_IDLE);

  // ****************************************
  // Programming sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rww_busy_next = rww_busy_reg;
    halt_next = halt_reg;
    reject_next = reject_reg;
    lock_next = lock_reg;
    start_next = 1'b0;
    erase_next = erase_reg;
    faddr_next = faddr_reg;
    case (state_reg)
      fspg_pkg::FSPG_IDLE: begin
        if (spm_legal && op == fspg_pkg::FSPG_OP_LOCK) begin
          lock_next = lock_reg & spm_lock_data;
        end else if (spm_legal && (op == fspg_pkg::FSPG_OP_ERASE ||
                                   op == fspg_pkg::FSPG_OP_WRITE)) begin
          if (lk_w.write_ok) begin
            state_next = fspg_pkg::FSPG_RUN;
            cnt_next = PROG_CYCLES;
            start_next = 1'b1;
            erase_next = (op == fspg_pkg::FSPG_OP_ERASE);
            faddr_next = spm_addr;
            rww_busy_next = 1'b1;
            halt_next = ~in_rww(spm_addr);
          end else begin
            reject_next = 1'b1;
          end
        end
      end
      fspg_pkg::FSPG_RUN: begin
        if (cnt_reg <= 16'h0001) begin
          state_next = fspg_pkg::FSPG_IDLE;
          halt_next = 1'b0;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      default: begin
        state_next = fspg_pkg::FSPG_IDLE;
      end
    endcase
    // Busy flag stays set until software re-enables reads after completion
    if (apb_wr && paddr == `FSPG_CTRL_OFS && pwdata[`FSPG_CTRL_RWW_RE_BIT] &&
        state_reg == fspg_pkg::FSPG_IDLE && !start_next) begin
      rww_busy_next = 1'b0;
    end
    if (apb_wr && paddr == `FSPG_STATUS_OFS && pwdata[`FSPG_STAT_REJECT_BIT] &&
        !(spm_legal && !lk_w.write_ok)) begin
      reject_next = 1'b0;
    end
    if (apb_wr && paddr == `FSPG_LOCK_OFS) begin
      lock_next = lock_next & pwdata[5:0];
    end
    if (chip_erase) begin
      lock_next = `FSPG_LOCK_RESET;
    end
  end

  // ****************************************
  // APB register access and guard outputs
  // ****************************************
  always_comb begin
    vec_boot_next = vec_boot_reg;
    boot_start_next = boot_start_reg;
    pready_next = psel & penable & ~pready_reg;
    pslverr_next = 1'b0;
    prdata_next = 32'h00000000;
    if (apb_wr) begin
      case (paddr)
        `FSPG_CTRL_OFS: vec_boot_next = pwdata[`FSPG_CTRL_VEC_BOOT_BIT];
        `FSPG_BOUND_OFS: begin
          // Start below the limit is refused so the boot section stays in NO_READ_WHILE_WRITE_SECTION
          if (pwdata[`FSPG_ADDR_W-1:0] >= RWW_LIMIT) begin
            boot_start_next = pwdata[`FSPG_ADDR_W-1:0];
          end else begin
            pslverr_next = 1'b1;
          end
        end
        `FSPG_STATUS_OFS, `FSPG_LOCK_OFS: pslverr_next = 1'b0;
        default: pslverr_next = 1'b1;
      endcase
    end
    if (apb_rd) begin
      case (paddr)
        `FSPG_CTRL_OFS: prdata_next = {30'h00000000, vec_boot_reg, 1'b0};
        `FSPG_STATUS_OFS: prdata_next = {29'h00000000, reject_reg, rww_busy_reg,
                                         state_reg == fspg_pkg::FSPG_RUN};
        `FSPG_LOCK_OFS: prdata_next = {26'h0000000, lock_reg};
        `FSPG_BOUND_OFS: prdata_next = {17'h00000, boot_start_reg};
        default: pslverr_next = 1'b1;
      endcase
    end
    // Fetches from READ_WHILE_WRITE_SECTION blocked while busy; CPU must not rely on them
    fetch_blk_next = rww_busy_next;
    lpm_ok_next = lpm_req & lk_r.read_ok & ~(rww_busy_reg & in_rww(lpm_addr));
    irq_dis_next = lk_r.irq_block;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= fspg_pkg::FSPG_IDLE;
      cnt_reg <= 16'h0000;
      rww_busy_reg <= 1'b0;
      halt_reg <= 1'b0;
      vec_boot_reg <= 1'b0;
      reject_reg <= 1'b0;
      lock_reg <= `FSPG_LOCK_RESET;
      boot_start_reg <= `FSPG_BOOT_START_RESET;
      prdata <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr <= 1'b0;
      fetch_blk_reg <= 1'b0;
      lpm_ok_reg <= 1'b0;
      irq_dis_reg <= 1'b0;
      start_reg <= 1'b0;
      erase_reg <= 1'b0;
      faddr_reg <= 15'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rww_busy_reg <= rww_busy_next;
      halt_reg <= halt_next;
      vec_boot_reg <= vec_boot_next;
      reject_reg <= reject_next;
      lock_reg <= lock_next;
      boot_start_reg <= boot_start_next;
      prdata <= prdata_next;
      pready_reg <= pready_next;
      pslverr <= pslverr_next;
      fetch_blk_reg <= fetch_blk_next;
      lpm_ok_reg <= lpm_ok_next;
      irq_dis_reg <= irq_dis_next;
      start_reg <= start_next;
      erase_reg <= erase_next;
      faddr_reg <= faddr_next;
    end
  end

  assign pready = pready_reg;
  assign cpu_halt = halt_reg;
  assign rww_fetch_block = fetch_blk_reg;
  assign lpm_allow = lpm_ok_reg;
  assign irq_disable = irq_dis_reg;
  assign flash_start = start_reg;
  assign flash_is_erase = erase_reg;
  assign flash_addr = faddr_reg;
endmodule
`default_nettype wire

/* verilog/fspg_lock_eval.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fspg_defines.svh"
module fspg_lock_eval (
  fspg_lock_if.guard lk
);
  logic app_wr_n;
  logic app_rd_n;
  logic boot_wr_n;
  logic boot_rd_n;

  assign app_wr_n = lk.lock_bits[`FSPG_LOCK_APP_WR_BIT];
  assign app_rd_n = lk.lock_bits[`FSPG_LOCK_APP_RD_BIT];
  assign boot_wr_n = lk.lock_bits[`FSPG_LOCK_BOOT_WR_BIT];
  assign boot_rd_n = lk.lock_bits[`FSPG_LOCK_BOOT_RD_BIT];

  // General lock bits are not consulted here on purpose
  always_comb begin
    if (lk.target_boot) begin
      lk.write_ok = boot_wr_n;
      lk.read_ok = lk.boot_pc | boot_rd_n;
    end else begin
      lk.write_ok = app_wr_n;
      lk.read_ok = ~lk.boot_pc | app_rd_n;
    end
    // Interrupt blocked when vectors sit in the other section and the running section is read-protected
    if (lk.boot_pc) begin
      lk.irq_block = ~boot_rd_n & ~lk.vec_boot;
    end else begin
      lk.irq_block = ~app_rd_n & lk.vec_boot;
    end
  end
endmodule
`default_nettype wire
